/* File: core/rcdsc_pkg.sv */
`default_nettype none
package rcdsc_pkg;
   // wishbone word offsets (byte addresses)
   localparam int ADR_W = 8;
   localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] OFS_LEN = 8'h04;
   localparam logic [ADR_W-1:0] OFS_MEAS = 8'h08;
   localparam logic [ADR_W-1:0] OFS_TIMING = 8'h0C;
   localparam logic [ADR_W-1:0] OFS_STAT = 8'h10;
   localparam logic [ADR_W-1:0] OFS_GPC = 8'h14;
   // field positions
   localparam int CTRL_SLEEP_ON = 0;
   localparam int CTRL_EXT_BLOCK = 1;
   localparam int STAT_PERMIT = 0;
   localparam int STAT_ASLEEP = 1;
   localparam int STAT_RADIO_UP = 2;
   localparam int STAT_CLK_EN = 3;
   localparam int GPC_WAKE_REQ = 0;
   localparam int LEAD_W = 8;
   localparam int ASSERT_LSB = 0;
   localparam int DEASSERT_LSB = 8;
   localparam int EXT_LSB = 16;
   localparam int CNT_W = 32;
   // reset values
   localparam logic [LEAD_W-1:0] ASSERT_RST = 8'h10;
   localparam logic [LEAD_W-1:0] DEASSERT_RST = 8'h01;
   localparam logic [LEAD_W-1:0] EXT_RST = 8'h02;
   localparam logic [CNT_W-1:0] LEN_RST = 32'h0000_0000;
   // timing: slot reference and low-power clock rates
   localparam int SLOT_US = 625;
   localparam int CLK_HZ = 25_000_000;
   localparam int LP_MAX_HZ = 32_768;
   // fast cycles per low-power half period, rounded down
   localparam int LP_HALF_CYC = CLK_HZ / (2 * LP_MAX_HZ);

   typedef enum logic [2:0]
   {
      ST_ACTIVE = 3'b000,
      ST_SWITCH = 3'b001,
      ST_SLEEP = 3'b010,
      ST_EXPIRED = 3'b011
   } rcdsc_state_e;

   typedef struct packed
   {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [ADR_W-1:0] adr;
      logic [31:0] dat;
   } rcdsc_wb_req_s;

   typedef struct packed
   {
      logic ack;
      logic [31:0] dat;
   } rcdsc_wb_rsp_s;

   typedef struct packed
   {
      logic lp_clk;
      logic clk_en;
      logic radio_up;
   } rcdsc_pins_s;

   typedef struct packed
   {
      rcdsc_state_e st;
      logic sleep_on;
      logic ext_block;
      logic wake_req;
      logic [CNT_W-1:0] len;
      logic [CNT_W-1:0] meas;
      logic [CNT_W-1:0] cnt;
      logic [LEAD_W-1:0] a_lead;
      logic [LEAD_W-1:0] d_lead;
      logic [LEAD_W-1:0] ext_len;
      logic [LEAD_W-1:0] ext_cnt;
      logic ext_wake;
      logic wake_seen;
      logic wake_irq;
      logic exit_irq;
      logic permit;
      logic ack;
      logic [31:0] rdat;
   } rcdsc_core_s;
endpackage : rcdsc_pkg
`default_nettype wire

/* File: core/rcdsc_sync.sv */
`default_nettype none
module rcdsc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } rcdsc_sync_s;

   rcdsc_sync_s r;
   rcdsc_sync_s n;

   // first stage feeds only the second
   always_comb
   begin
      n.s1 = d_i;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r <= '0;
      else
         r <= n;
   end

   assign q_o = r.s2;
endmodule : rcdsc_sync
`default_nettype wire

/* File: core/rcdsc_edge.sv */
`default_nettype none
module rcdsc_edge (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // synchronised level in, rising-edge pulse out
   input wire logic lvl_i,
   output logic rise_o
);
   typedef struct packed
   {
      logic prev;
      logic rise;
   } rcdsc_edge_s;

   rcdsc_edge_s r;
   rcdsc_edge_s n;

   always_comb
   begin
      n.prev = lvl_i;
      n.rise = lvl_i & ~r.prev;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r <= '0;
      else
         r <= n;
   end

   assign rise_o = r.rise;
endmodule : rcdsc_edge
`default_nettype wire

/* File: core/rcdsc_top.sv */
// Summary of operation
// - in deep sleep the base timing runs from low-power clock ticks
// - power-down-allowed status goes high once the clock switch is done
// - sleep ends on timer expiry or on a software wake request
// - scheduled wake interrupt rises a programmed lead before wake time
// - after expiry the timer waits in sleep until core is powered up
// - measured sleep length includes any delay waiting for power-up
// - exit interrupt needs expiry, clocks enabled and radio up together
// - writing the wake request raises the wake interrupt at once
// - external wake interrupt high time set by the pulse length field less the deassert lead
// - sleep requests are refused while the wake request stays high
// - the block bit makes the core ignore the wake request
// - exit always shows wake interrupt first, then exit interrupt
// - assert lead: low-power cycles before expiry the wake rises
// - deassert lead: low-power cycles before the end the wake drops
`default_nettype none
module rcdsc_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire rcdsc_pkg::rcdsc_wb_req_s wb_req_i,
   output rcdsc_pkg::rcdsc_wb_rsp_s wb_rsp_o,
   // asynchronous pins: low-power clock, clock enable, radio power state
   input wire rcdsc_pkg::rcdsc_pins_s pins_i,
   // event and status outputs
   output logic wake_interrupt_o,
   output logic sleep_exit_interrupt_o,
   output logic radio_off_permitted_o
);
   import rcdsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisation and low-power tick

   rcdsc_pins_s pins_s;
   logic lp_tick;

   rcdsc_sync #(
      .W(3)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pins_i),
      .q_o(pins_s)
   );

   // the low-power clock is slow enough to be sampled as a level
   rcdsc_edge u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lvl_i(pins_s.lp_clk),
      .rise_o(lp_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // state

   rcdsc_core_s r;
   rcdsc_core_s n;

   logic bus_wr;
   logic bus_hit;
   logic ext_req;
   logic core_up;
   logic sched_on;
   logic [CNT_W-1:0] rem;
   logic [CNT_W-1:0] cnt_inc;
   logic [31:0] rd_word;

   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] sel
   );
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            res[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return res;
   endfunction : lane_merge

   ////////////////////////////////////////////////////////////////////////
   // derived terms

   always_comb
   begin
      bus_hit = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
      bus_wr = bus_hit & wb_req_i.we;
      ext_req = r.wake_req & ~r.ext_block;
      core_up = pins_s.clk_en & pins_s.radio_up;
      rem = r.len - r.cnt;
      cnt_inc = r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      // window between assert lead and deassert lead
      sched_on = (rem <= {{(CNT_W-LEAD_W){1'b0}}, r.a_lead})
         && (rem > {{(CNT_W-LEAD_W){1'b0}}, r.d_lead});
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux

   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (wb_req_i.adr)
         OFS_CTRL:
         begin
            rd_word[CTRL_SLEEP_ON] = r.sleep_on;
            rd_word[CTRL_EXT_BLOCK] = r.ext_block;
         end
         OFS_LEN: rd_word = r.len;
         OFS_MEAS: rd_word = r.meas;
         OFS_TIMING:
         begin
            rd_word[ASSERT_LSB +: LEAD_W] = r.a_lead;
            rd_word[DEASSERT_LSB +: LEAD_W] = r.d_lead;
            rd_word[EXT_LSB +: LEAD_W] = r.ext_len;
         end
         OFS_STAT:
         begin
            rd_word[STAT_PERMIT] = r.permit;
            rd_word[STAT_ASLEEP] = (r.st != ST_ACTIVE);
            rd_word[STAT_RADIO_UP] = pins_s.radio_up;
            rd_word[STAT_CLK_EN] = pins_s.clk_en;
         end
         OFS_GPC: rd_word[GPC_WAKE_REQ] = r.wake_req;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state: sequencer first, bus writes last so a set wins

   always_comb
   begin
      n = r;
      n.ack = bus_hit;
      n.rdat = bus_hit ? rd_word : 32'h0000_0000;
      n.exit_irq = 1'b0;

      case (r.st)
         ST_ACTIVE:
         begin
            n.wake_irq = 1'b0;
            if (r.sleep_on && ext_req)
            begin
               // a pending wake request turns the entry down
               n.sleep_on = 1'b0;
            end
            else if (r.sleep_on)
            begin
               n.st = ST_SWITCH;
               n.cnt = '0;
               n.wake_seen = 1'b0;
               n.ext_wake = 1'b0;
            end
         end
         ST_SWITCH:
         begin
            if (ext_req)
            begin
               n.st = ST_EXPIRED;
               n.ext_wake = 1'b1;
               n.wake_irq = 1'b1;
               n.wake_seen = 1'b1;
               n.ext_cnt = r.ext_len;
            end
            else if (lp_tick)
            begin
               // base time now follows the low-power clock
               n.st = ST_SLEEP;
               n.permit = 1'b1;
            end
         end
         ST_SLEEP:
         begin
            if (ext_req)
            begin
               // sleep timing cut short by the wake request; the count keeps running
               n.st = ST_EXPIRED;
               n.ext_wake = 1'b1;
               n.wake_irq = 1'b1;
               n.wake_seen = 1'b1;
               n.ext_cnt = r.ext_len;
            end
            else
            begin
               n.wake_irq = sched_on;
               if (sched_on)
                  n.wake_seen = 1'b1;
               if (lp_tick)
               begin
                  n.cnt = cnt_inc;
                  if (cnt_inc >= r.len)
                     n.st = ST_EXPIRED;
               end
            end
         end
         ST_EXPIRED:
         begin
            // keep measuring the real sleep length while waiting
            if (lp_tick)
               n.cnt = cnt_inc;
            if (r.ext_wake)
            begin
               if (lp_tick && r.ext_cnt != '0)
                  n.ext_cnt = r.ext_cnt - {{(LEAD_W-1){1'b0}}, 1'b1};
               n.wake_irq = (r.ext_cnt > r.d_lead);
            end
            else if (!r.wake_seen)
            begin
               // leads left no window: still give one wake pulse
               n.wake_irq = 1'b1;
               n.wake_seen = 1'b1;
            end
            else if (lp_tick)
               n.wake_irq = 1'b0;
            // stays asleep until clocks and radio are back
            if (r.wake_seen && !r.wake_irq && core_up)
            begin
               n.st = ST_ACTIVE;
               n.exit_irq = 1'b1;
               n.meas = r.cnt;
               n.sleep_on = 1'b0;
               n.permit = 1'b0;
            end
         end
         default:
         begin
            n.st = ST_ACTIVE;
            n.wake_irq = 1'b0;
            n.permit = 1'b0;
         end
      endcase

      if (bus_wr)
      begin
         case (wb_req_i.adr)
            OFS_CTRL:
            begin
               if (wb_req_i.sel[0])
               begin
                  if (wb_req_i.dat[CTRL_SLEEP_ON] && r.st == ST_ACTIVE)
                     n.sleep_on = 1'b1;
                  n.ext_block = wb_req_i.dat[CTRL_EXT_BLOCK];
               end
            end
            OFS_LEN: n.len = lane_merge(r.len, wb_req_i.dat, wb_req_i.sel);
            OFS_TIMING:
            begin
               if (wb_req_i.sel[0])
                  n.a_lead = wb_req_i.dat[ASSERT_LSB +: LEAD_W];
               if (wb_req_i.sel[1])
                  n.d_lead = wb_req_i.dat[DEASSERT_LSB +: LEAD_W];
               if (wb_req_i.sel[2])
                  n.ext_len = wb_req_i.dat[EXT_LSB +: LEAD_W];
            end
            OFS_GPC:
            begin
               if (wb_req_i.sel[0])
                  n.wake_req = wb_req_i.dat[GPC_WAKE_REQ];
            end
            default: n.ack = bus_hit;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r <= '0;
         r.st <= ST_ACTIVE;
         r.len <= LEN_RST;
         r.a_lead <= ASSERT_RST;
         r.d_lead <= DEASSERT_RST;
         r.ext_len <= EXT_RST;
      end
      else
         r <= n;
   end

   assign wb_rsp_o.ack = r.ack;
   assign wb_rsp_o.dat = r.rdat;
   assign wake_interrupt_o = r.wake_irq;
   assign sleep_exit_interrupt_o = r.exit_irq;
   assign radio_off_permitted_o = r.permit;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_exit_needs_up:
   assert property (r.exit_irq |-> $past(core_up) && $past(r.st) == ST_EXPIRED)
      else $error("exit without expiry or power-up");

   a_wake_before_exit:
   assert property (r.exit_irq |-> $past(r.wake_seen) && !$past(r.wake_irq))
      else $error("exit without prior wake interrupt");

   a_ext_wake_now:
   assert property ((r.st == ST_SLEEP && ext_req) |=> r.wake_irq ##0 r.st == ST_EXPIRED)
      else $error("wake request did not raise wake at once");

   a_refuse_entry:
   assert property ((r.st == ST_ACTIVE && ext_req) |=> r.st == ST_ACTIVE)
      else $error("sleep entered while wake request high");

   a_permit_switch:
   assert property ((r.st == ST_SWITCH && lp_tick && !ext_req) |=> r.permit && r.st == ST_SLEEP)
      else $error("permit not raised after clock switch");

   a_wait_power:
   assert property ((r.st == ST_EXPIRED && !core_up) |=> r.st == ST_EXPIRED && !r.exit_irq)
      else $error("left sleep before power-up");

   a_meas_length:
   assert property ((r.exit_irq && !r.ext_wake) |-> r.meas >= r.len)
      else $error("measured sleep shorter than programmed");

   a_count_tick:
   assert property ((r.st == ST_SLEEP && lp_tick && !ext_req) |=> r.cnt == $past(r.cnt) + 32'h0000_0001)
      else $error("sleep timer missed a tick");

   a_sched_wake:
   assert property ((r.st == ST_SLEEP && !ext_req && sched_on) |=> r.wake_irq)
      else $error("scheduled wake not raised in window");

   a_block_ext:
   assert property ((r.st == ST_SLEEP && r.ext_block && !sched_on && !lp_tick) |=> !r.wake_irq)
      else $error("blocked wake request raised wake");
endmodule : rcdsc_top
`default_nettype wire

/* File: tb/test_rcdsc_top.sv */
`default_nettype none
module test_rcdsc_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rcdsc_pkg::*;
   // clk_i cycles per slow-clock period
   localparam int TICK = 763;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic lp = 1'b0;
   logic ce = 1'b1;
   logic ru = 1'b1;
   rcdsc_pins_s pins;
   rcdsc_wb_req_s wb_req = '0;
   rcdsc_wb_rsp_s wb_rsp;
   logic wake;
   logic exit_irq;
   logic permit;
   logic [31:0] rd;
   int num_errors = 0;
   int compares = 0;
   int exits = 0;
   int wakes = 0;
   int ex_wakes = 0;
   int w0;
   int e0;

   always #20 clk_i = ~clk_i;
   // slow clock runs free, phase unrelated to clk_i
   always #15259 lp = ~lp;
   assign pins = '{lp_clk: lp, clk_en: ce, radio_up: ru};

   rcdsc_top rcdsc_top_i (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_req_i(wb_req),
      .wb_rsp_o(wb_rsp),
      .pins_i(pins),
      .wake_interrupt_o(wake),
      .sleep_exit_interrupt_o(exit_irq),
      .radio_off_permitted_o(permit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // event history: wake-high cycles seen before each exit pulse
   always @(posedge clk_i)
   begin
      if (wake === 1'b1)
         wakes <= wakes + 1;
      if (exit_irq === 1'b1)
      begin
         exits <= exits + 1;
         ex_wakes <= wakes;
      end
   end

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // classic single cycle; entered just after a rising edge
   // a missing ack is left to the watchdog
   task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: d};
      do
      begin
         @(posedge clk_i);
      end
      while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat;
      wb_req <= '0;
      @(posedge clk_i);
      // ack stands for one cycle only
      chk("ack drop", 32'h0000_0000, {31'h0, wb_rsp.ack});
   endtask : wb

   // which: 0 wake high, 1 exit pulse, 2 permitted high, 3 wake low
   task wait_on(input string what, input int which, input int lim);
      int n;
      logic s;
      n = 0;
      s = 1'b0;
      while (n < lim && s !== 1'b1)
      begin
         @(posedge clk_i);
         n++;
         case (which)
            0: s = wake;
            1: s = exit_irq;
            2: s = permit;
            default: s = ~wake;
         endcase
      end
      chk(what, 32'h0000_0001, {31'h0, s});
   endtask : wait_on

   task sleep_in(input logic [31:0] tim, input logic [31:0] len, input logic [31:0] ctl);
      wb(1'b1, OFS_TIMING, tim);
      wb(1'b1, OFS_LEN, len);
      wb(1'b1, OFS_CTRL, ctl);
      wait_on("permitted", 2, 3 * TICK);
      ce <= 1'b0;
      ru <= 1'b0;
      @(posedge clk_i);
   endtask : sleep_in

   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk("permitted", 32'h0000_0000, {31'h0, permit});
      wb(1'b0, OFS_TIMING, 32'h0000_0000);
      chk("timing", 32'h0002_0110, rd);
      wb(1'b0, OFS_LEN, 32'h0000_0000);
      chk("length", 32'h0000_0000, rd);
      wb(1'b1, 8'h40, 32'hffff_ffff);
      wb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, rd);
      $display("t_reset done");
   endtask : t_reset

   task t_sched;
      w0 = wakes;
      e0 = exits;
      sleep_in(32'h0002_0104, 32'h0000_000a, 32'h0000_0001);
      wb(1'b0, OFS_STAT, 32'h0000_0000);
      chk("asleep", 32'h0000_0001, {31'h0, rd[STAT_ASLEEP]});
      wait_on("wake rise", 0, 14 * TICK);
      wait_on("wake fall", 3, 6 * TICK);
      // past expiry with the core still powered down
      repeat (6 * TICK) @(posedge clk_i);
      chk("early exit", 32'(e0), 32'(exits));
      ce <= 1'b1;
      repeat (3 * TICK) @(posedge clk_i);
      chk("exit w/o radio", 32'(e0), 32'(exits));
      ru <= 1'b1;
      wait_on("exit", 1, 2 * TICK);
      @(posedge clk_i);
      chk("exit count", 32'(e0 + 1), 32'(exits));
      chk("wake first", 32'h0000_0001, {31'h0, ex_wakes > w0});
      wb(1'b0, OFS_MEAS, 32'h0000_0000);
      chk("measured long", 32'h0000_0001, {31'h0, rd > 32'h0000_000a});
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk("sleep bit", 32'h0000_0000, {31'h0, rd[CTRL_SLEEP_ON]});
      chk("permitted off", 32'h0000_0000, {31'h0, permit});
      $display("t_sched done");
   endtask : t_sched

   task t_ext;
      w0 = wakes;
      e0 = exits;
      sleep_in(32'h0002_0104, 32'h0000_03e8, 32'h0000_0001);
      wb(1'b1, OFS_GPC, 32'h0000_0001);
      chk("wake now", 32'h0000_0001, {31'h0, wake});
      wait_on("wake pulse end", 3, TICK + 20);
      ce <= 1'b1;
      ru <= 1'b1;
      wait_on("ext exit", 1, 3 * TICK);
      @(posedge clk_i);
      chk("ext wake first", 32'h0000_0001, {31'h0, ex_wakes > w0});
      wb(1'b1, OFS_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk_i);
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk("refused sleep", 32'h0000_0000, {31'h0, rd[CTRL_SLEEP_ON]});
      chk("no permit", 32'h0000_0000, {31'h0, permit});
      wb(1'b1, OFS_GPC, 32'h0000_0000);
      $display("t_ext done");
   endtask : t_ext

   task t_block;
      sleep_in(32'h0002_0104, 32'h0000_03e8, 32'h0000_0003);
      w0 = wakes;
      wb(1'b1, OFS_GPC, 32'h0000_0001);
      repeat (2 * TICK) @(posedge clk_i);
      chk("blocked wake", 32'(w0), 32'(wakes));
      wb(1'b0, OFS_STAT, 32'h0000_0000);
      chk("still asleep", 32'h0000_0001, {31'h0, rd[STAT_ASLEEP]});
      wb(1'b1, OFS_GPC, 32'h0000_0000);
      $display("t_block done");
   endtask : t_block

   task close_out;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_sched();
      t_ext();
      t_block();
      close_out();
   end

   // whole run is cut off after 60000 cycles, about 79 slow periods
   initial
   begin
      repeat (60000) @(posedge clk_i);
      num_errors++;
      close_out();
   end
endmodule : test_rcdsc_top
`default_nettype wire
